// >>> shared/crtvt_pkg.sv
// Constants, register indices and types for the raster timing block.
// Assumes one core clock; character rate comes from an enable divider.
package crtvt_pkg;

  // Register indices as loaded into the pointer register
  localparam logic [4:0] IDX_HORIZ_TOTAL = 5'h00;
  localparam logic [4:0] IDX_HORIZ_DISPLAYED = 5'h01;
  localparam logic [4:0] IDX_HORIZ_SYNC_POS = 5'h02;
  localparam logic [4:0] IDX_SYNC_PULSE_WIDTHS = 5'h03;
  localparam logic [4:0] IDX_VERTICAL_TOTAL = 5'h04;
  localparam logic [4:0] IDX_VERTICAL_TOTAL_ADJUST = 5'h05;
  localparam logic [4:0] IDX_VERTICAL_DISPLAYED = 5'h06;
  localparam logic [4:0] IDX_VERTICAL_SYNC_POSITION = 5'h07;
  localparam logic [4:0] IDX_INTERLACE_AND_SKEW = 5'h08;
  localparam logic [4:0] IDX_MAX_RASTER_ADDRESS = 5'h09;
  localparam logic [4:0] IDX_CURSOR_START_RASTER = 5'h0a;
  localparam logic [4:0] IDX_CURSOR_END_RASTER = 5'h0b;
  localparam logic [4:0] IDX_REFRESH_START_HIGH = 5'h0c;
  localparam logic [4:0] IDX_REFRESH_START_LOW = 5'h0d;
  localparam logic [4:0] IDX_CURSOR_LOCATION_HIGH = 5'h0e;
  localparam logic [4:0] IDX_CURSOR_LOCATION_LOW = 5'h0f;
  localparam logic [4:0] IDX_PEN_CAPTURE_HIGH = 5'h10;
  localparam logic [4:0] IDX_PEN_CAPTURE_LOW = 5'h11;

  // Field positions
  localparam int HSW_LSB = 0;
  localparam int VSW_LSB = 4;
  localparam int SCAN_MODE_LSB = 0;
  localparam int ENABLE_DELAY_LSB = 4;
  localparam int CURSOR_DELAY_LSB = 6;
  localparam int CURSOR_MODE_LSB = 5;
  localparam int BLINK16_BIT = 3;
  localparam int BLINK32_BIT = 4;

  // Reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [13:0] ADDR_RESET = 14'h0000;

  // Default character clock divide (core clocks per character)
  localparam int CHAR_DIV_DEFAULT = 1;

  typedef enum logic [1:0] {
    CUR_STEADY,
    CUR_HIDDEN,
    CUR_BLINK16,
    CUR_BLINK32
  } crtvt_cursor_mode_type;

  typedef enum logic [1:0] {
    SKEW_NONE,
    SKEW_ONE,
    SKEW_TWO,
    SKEW_OFF
  } crtvt_skew_type;

  typedef enum logic [1:0] {
    SCAN_PLAIN,
    SCAN_INTERLACE_SYNC,
    SCAN_PLAIN_ALT,
    SCAN_INTERLACE_VIDEO
  } crtvt_scan_type;

endpackage

// >>> logic/crtvt_sync2.sv
// Two-stage synchroniser for a bundle of pin inputs.
// Assumes the inputs are asynchronous to core_clk.
`timescale 1ns/1ps
module crtvt_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_q <= '0;
      sync_out <= '0;
    end else begin
      stage1_q <= async_in;
      sync_out <= stage1_q;
    end
  end
endmodule

// >>> logic/crtvt_skew.sv
// Selectable zero, one or two character delay of one timing signal.
// Assumes char_en pulses once per character time.
`timescale 1ns/1ps
module crtvt_skew
  import crtvt_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic char_en,
  input crtvt_pkg::crtvt_skew_type skew_sel,
  input wire logic sig_in,
  output logic sig_out
);
  logic [1:0] delay_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      delay_q <= 2'h0;
      sig_out <= 1'b0;
    end else if (clear) begin
      delay_q <= 2'h0;
      sig_out <= 1'b0;
    end else if (char_en) begin
      delay_q <= {delay_q[0], sig_in};
      case (skew_sel)
        SKEW_NONE: sig_out <= sig_in;
        SKEW_ONE: sig_out <= delay_q[0];
        SKEW_TWO: sig_out <= delay_q[1];
        SKEW_OFF: sig_out <= 1'b0;
        default: sig_out <= 1'b0;
      endcase
    end
  end
endmodule

// >>> logic/crtvt_core.sv
// Raster timing core: indirect register file, counters, syncs, cursor, light pen.
// Assumes host bus and pen pins are asynchronous and pass synchronisers.
`timescale 1ns/1ps

module crtvt_core
  import crtvt_pkg::*;
#(
  parameter int CHAR_DIV = CHAR_DIV_DEFAULT
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic reset_low_in,
  input wire logic pen_strobe_in,
  input wire logic bus_e,
  input wire logic bus_cs_n,
  input wire logic register_select,
  input wire logic bus_read,
  input wire logic [7:0] bus_data_in,
  output logic [7:0] bus_data_out,
  output logic bus_data_oe,
  output logic hsync_out,
  output logic vsync_out,
  output logic display_enable_out,
  output logic cursor_video_out,
  output logic [13:0] refresh_addr_out,
  output logic [4:0] raster_addr_out
);
  typedef enum {VP_ROWS, VP_ADJUST} crtvt_vphase_type;

  // Synchronised pins
  logic [11:0] bus_s;
  logic [1:0] misc_s;
  logic e_s, cs_n_s, sel_s, rd_s;
  logic [7:0] din_s;
  logic res_s, pen_s;

  crtvt_sync2 #(.WIDTH(12)) u_bus_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in({bus_e, bus_cs_n, register_select, bus_read, bus_data_in}),
    .sync_out(bus_s)
  );

  crtvt_sync2 #(.WIDTH(2)) u_misc_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in({reset_low_in, pen_strobe_in}),
    .sync_out(misc_s)
  );

  assign {e_s, cs_n_s, sel_s, rd_s, din_s} = bus_s;
  assign {res_s, pen_s} = misc_s;

  // Register file
  logic [4:0] pointer_register_q;
  logic [7:0] horiz_total_q, horiz_displayed_q, horiz_sync_pos_q;
  logic [7:0] sync_pulse_widths_q, interlace_and_skew_q;
  logic [6:0] vertical_total_q, vertical_displayed_q, vertical_sync_position_q;
  logic [4:0] vertical_total_adjust_q, max_raster_address_q, cursor_end_raster_q;
  logic [6:0] cursor_start_raster_q;
  logic [13:0] refresh_start_q, cursor_location_q, pen_capture_q;
  logic e_prev_q;
  logic host_write;

  assign host_write = e_prev_q && !e_s && !cs_n_s && !rd_s;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      e_prev_q <= 1'b0;
    end else begin
      e_prev_q <= e_s;
    end
  end

  // Writes land on the falling edge of the synchronised enable strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pointer_register_q <= 5'h00;
      horiz_total_q <= REG_RESET;
      horiz_displayed_q <= REG_RESET;
      horiz_sync_pos_q <= REG_RESET;
      sync_pulse_widths_q <= REG_RESET;
      interlace_and_skew_q <= REG_RESET;
      vertical_total_q <= REG_RESET[6:0];
      vertical_total_adjust_q <= REG_RESET[4:0];
      vertical_displayed_q <= REG_RESET[6:0];
      vertical_sync_position_q <= REG_RESET[6:0];
      max_raster_address_q <= REG_RESET[4:0];
      cursor_start_raster_q <= REG_RESET[6:0];
      cursor_end_raster_q <= REG_RESET[4:0];
      refresh_start_q <= ADDR_RESET;
      cursor_location_q <= ADDR_RESET;
    end else if (host_write) begin
      if (!sel_s) begin
        pointer_register_q <= din_s[4:0];
      end else begin
        case (pointer_register_q)
          IDX_HORIZ_TOTAL: horiz_total_q <= din_s;
          IDX_HORIZ_DISPLAYED: horiz_displayed_q <= din_s;
          IDX_HORIZ_SYNC_POS: horiz_sync_pos_q <= din_s;
          IDX_SYNC_PULSE_WIDTHS: sync_pulse_widths_q <= din_s;
          IDX_VERTICAL_TOTAL: vertical_total_q <= din_s[6:0];
          IDX_VERTICAL_TOTAL_ADJUST: vertical_total_adjust_q <= din_s[4:0];
          IDX_VERTICAL_DISPLAYED: vertical_displayed_q <= din_s[6:0];
          IDX_VERTICAL_SYNC_POSITION: vertical_sync_position_q <= din_s[6:0];
          IDX_INTERLACE_AND_SKEW: interlace_and_skew_q <= din_s;
          IDX_MAX_RASTER_ADDRESS: max_raster_address_q <= din_s[4:0];
          IDX_CURSOR_START_RASTER: cursor_start_raster_q <= din_s[6:0];
          IDX_CURSOR_END_RASTER: cursor_end_raster_q <= din_s[4:0];
          IDX_REFRESH_START_HIGH: refresh_start_q[13:8] <= din_s[5:0];
          IDX_REFRESH_START_LOW: refresh_start_q[7:0] <= din_s;
          IDX_CURSOR_LOCATION_HIGH: cursor_location_q[13:8] <= din_s[5:0];
          IDX_CURSOR_LOCATION_LOW: cursor_location_q[7:0] <= din_s;
          default: ;
        endcase
      end
    end
  end

  // Read multiplexer: only start, cursor and pen pairs read back
  function automatic logic [7:0] read_mux(input logic [4:0] idx);
    case (idx)
      IDX_REFRESH_START_HIGH: read_mux = {2'h0, refresh_start_q[13:8]};
      IDX_REFRESH_START_LOW: read_mux = refresh_start_q[7:0];
      IDX_CURSOR_LOCATION_HIGH: read_mux = {2'h0, cursor_location_q[13:8]};
      IDX_CURSOR_LOCATION_LOW: read_mux = cursor_location_q[7:0];
      IDX_PEN_CAPTURE_HIGH: read_mux = {2'h0, pen_capture_q[13:8]};
      IDX_PEN_CAPTURE_LOW: read_mux = pen_capture_q[7:0];
      default: read_mux = 8'h00;
    endcase
  endfunction

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_data_out <= 8'h00;
      bus_data_oe <= 1'b0;
    end else begin
      bus_data_oe <= e_s && !cs_n_s && rd_s && sel_s;
      bus_data_out <= read_mux(pointer_register_q);
    end
  end

  // Field decode
  crtvt_scan_type scan_mode;
  crtvt_cursor_mode_type cursor_mode;
  crtvt_skew_type cursor_skew, enable_skew;
  logic [3:0] horizontal_width_field;
  logic [4:0] vertical_width_field;

  assign scan_mode = crtvt_scan_type'(interlace_and_skew_q[SCAN_MODE_LSB +: 2]);
  assign cursor_skew = crtvt_skew_type'(interlace_and_skew_q[CURSOR_DELAY_LSB +: 2]);
  assign enable_skew = crtvt_skew_type'(interlace_and_skew_q[ENABLE_DELAY_LSB +: 2]);
  assign cursor_mode = crtvt_cursor_mode_type'(cursor_start_raster_q[CURSOR_MODE_LSB +: 2]);
  assign horizontal_width_field = sync_pulse_widths_q[HSW_LSB +: 4];
  // Zero in the vertical field means sixteen lines
  assign vertical_width_field = (sync_pulse_widths_q[VSW_LSB +: 4] == 4'h0) ? 5'h10 :
               {1'b0, sync_pulse_widths_q[VSW_LSB +: 4]};

  // Counter clear: pin reset only acts while the pen strobe is low
  logic run_clear;
  assign run_clear = !res_s && !pen_s;

  // Character clock enable
  logic [7:0] div_q;
  logic char_en;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 8'h00;
    end else if (run_clear || div_q == 8'(CHAR_DIV - 1)) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  assign char_en = !run_clear && (div_q == 8'(CHAR_DIV - 1));

  // Timing counters
  crtvt_vphase_type vphase_q;
  logic [7:0] h_cnt_q;
  logic [6:0] row_q;
  logic [4:0] ra_q, adj_q;
  logic [13:0] ma_q, ma_row_q, ma_row_d;
  logic [4:0] frame_cnt_q;
  logic video_mode, interlaced, next_field;
  logic [4:0] ra_start, ra_step, ra_start_next;
  logic h_end, ra_last, row_done, frame_done;

  assign video_mode = (scan_mode == SCAN_INTERLACE_VIDEO);
  assign interlaced = (scan_mode == SCAN_INTERLACE_SYNC) || video_mode;
  assign next_field = ~frame_cnt_q[0];
  // Video mode scans every other raster, odd field starting on raster one
  assign ra_start = video_mode ? {4'h0, frame_cnt_q[0]} : 5'h00;
  assign ra_start_next = video_mode ? {4'h0, next_field} : 5'h00;
  assign ra_step = video_mode ? 5'h02 : 5'h01;
  assign ra_last = video_mode ? (ra_q >= max_raster_address_q) :
                   (ra_q == max_raster_address_q);
  assign h_end = (h_cnt_q == horiz_total_q);
  assign row_done = h_end && (vphase_q == VP_ROWS) && ra_last;
  assign frame_done = h_end && (((vphase_q == VP_ROWS) && ra_last &&
                      (row_q == vertical_total_q) && (vertical_total_adjust_q == 5'h00)) ||
                      ((vphase_q == VP_ADJUST) &&
                      (5'(adj_q + 5'h01) == vertical_total_adjust_q)));
  assign ma_row_d = frame_done ? refresh_start_q :
                    row_done ? 14'(ma_row_q + {6'h00, horiz_displayed_q}) :
                    ma_row_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      h_cnt_q <= 8'h00;
    end else if (run_clear) begin
      h_cnt_q <= 8'h00;
    end else if (char_en) begin
      h_cnt_q <= h_end ? 8'h00 : 8'(h_cnt_q + 8'h01);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      vphase_q <= VP_ROWS;
      row_q <= 7'h00;
      ra_q <= 5'h00;
      adj_q <= 5'h00;
      frame_cnt_q <= 5'h00;
    end else if (run_clear) begin
      vphase_q <= VP_ROWS;
      row_q <= 7'h00;
      ra_q <= 5'h00;
      adj_q <= 5'h00;
      frame_cnt_q <= 5'h00;
    end else if (char_en && h_end) begin
      if (frame_done) begin
        vphase_q <= VP_ROWS;
        row_q <= 7'h00;
        ra_q <= ra_start_next;
        adj_q <= 5'h00;
        frame_cnt_q <= 5'(frame_cnt_q + 5'h01);
      end else if (vphase_q == VP_ADJUST) begin
        adj_q <= 5'(adj_q + 5'h01);
        ra_q <= 5'(ra_q + 5'h01);
      end else if (ra_last) begin
        ra_q <= ra_start;
        if (row_q == vertical_total_q) begin
          vphase_q <= VP_ADJUST;
          ra_q <= 5'h00;
        end else begin
          row_q <= 7'(row_q + 7'h01);
        end
      end else begin
        ra_q <= 5'(ra_q + ra_step);
      end
    end
  end

  // Refresh address: per character, reloaded from the row base each line
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ma_q <= ADDR_RESET;
      ma_row_q <= ADDR_RESET;
    end else if (run_clear) begin
      ma_q <= refresh_start_q;
      ma_row_q <= refresh_start_q;
    end else if (char_en) begin
      ma_row_q <= h_end ? ma_row_d : ma_row_q;
      ma_q <= h_end ? ma_row_d : 14'(ma_q + 14'h0001);
    end
  end

  // Horizontal sync
  logic [3:0] hs_cnt_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hsync_out <= 1'b0;
      hs_cnt_q <= 4'h0;
    end else if (run_clear) begin
      hsync_out <= 1'b0;
      hs_cnt_q <= 4'h0;
    end else if (char_en) begin
      if (!hsync_out && h_cnt_q == horiz_sync_pos_q && horizontal_width_field != 4'h0) begin
        hsync_out <= 1'b1;
        hs_cnt_q <= 4'h1;
      end else if (hsync_out) begin
        if (hs_cnt_q >= horizontal_width_field) begin
          hsync_out <= 1'b0;
        end else begin
          hs_cnt_q <= 4'(hs_cnt_q + 4'h1);
        end
      end
    end
  end

  // Vertical sync; odd interlaced fields tick at mid line
  logic [4:0] vs_cnt_q;
  logic vtick;

  assign vtick = (interlaced && frame_cnt_q[0]) ?
                 (h_cnt_q == {1'b0, horiz_total_q[7:1]}) : (h_cnt_q == 8'h00);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      vsync_out <= 1'b0;
      vs_cnt_q <= 5'h00;
    end else if (run_clear) begin
      vsync_out <= 1'b0;
      vs_cnt_q <= 5'h00;
    end else if (char_en && vtick) begin
      if (!vsync_out && vphase_q == VP_ROWS && row_q == vertical_sync_position_q &&
          ra_q == ra_start) begin
        vsync_out <= 1'b1;
        vs_cnt_q <= 5'h01;
      end else if (vsync_out) begin
        if (vs_cnt_q >= vertical_width_field) begin
          vsync_out <= 1'b0;
        end else begin
          vs_cnt_q <= 5'(vs_cnt_q + 5'h01);
        end
      end
    end
  end

  // Display enable and cursor before skew
  logic de_raw, cur_raw, blink_on;

  always_comb begin
    case (cursor_mode)
      CUR_STEADY: blink_on = 1'b1;
      CUR_HIDDEN: blink_on = 1'b0;
      CUR_BLINK16: blink_on = frame_cnt_q[BLINK16_BIT];
      CUR_BLINK32: blink_on = frame_cnt_q[BLINK32_BIT];
      default: blink_on = 1'b0;
    endcase
  end

  assign de_raw = (h_cnt_q < horiz_displayed_q) && (row_q < vertical_displayed_q) &&
                  (vphase_q == VP_ROWS);
  assign cur_raw = blink_on && de_raw && (ma_q == cursor_location_q) &&
                   (ra_q >= cursor_start_raster_q[4:0]) &&
                   (ra_q <= cursor_end_raster_q);

  crtvt_skew u_enable_skew (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clear(run_clear),
    .char_en(char_en),
    .skew_sel(enable_skew),
    .sig_in(de_raw),
    .sig_out(display_enable_out)
  );

  crtvt_skew u_cursor_skew (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clear(run_clear),
    .char_en(char_en),
    .skew_sel(cursor_skew),
    .sig_in(cur_raw),
    .sig_out(cursor_video_out)
  );

  // Address outputs
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      refresh_addr_out <= ADDR_RESET;
      raster_addr_out <= 5'h00;
    end else if (run_clear) begin
      refresh_addr_out <= ADDR_RESET;
      raster_addr_out <= 5'h00;
    end else begin
      refresh_addr_out <= ma_q;
      raster_addr_out <= ra_q;
    end
  end

  // Light pen capture on rising edge of the synchronised strobe
  logic pen_prev_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pen_prev_q <= 1'b0;
      pen_capture_q <= ADDR_RESET;
    end else begin
      pen_prev_q <= pen_s;
      if (pen_s && !pen_prev_q) begin
        pen_capture_q <= ma_q;
      end
    end
  end
endmodule

// >>> testbench/crtvt_core_properties.sv
// Checker for the raster timing core, bound to every crtvt_core instance.
// Assumes bus pins pass two sync flops and one output register.
`timescale 1ns/1ps
module crtvt_core_properties
  import crtvt_pkg::*;
#(
  parameter int CHAR_DIV = 1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic reset_low_in,
  input wire logic pen_strobe_in,
  input wire logic bus_e,
  input wire logic bus_cs_n,
  input wire logic register_select,
  input wire logic bus_read,
  input wire logic [7:0] bus_data_in,
  input wire logic [7:0] bus_data_out,
  input wire logic bus_data_oe,
  input wire logic hsync_out,
  input wire logic vsync_out,
  input wire logic display_enable_out,
  input wire logic cursor_video_out,
  input wire logic [13:0] refresh_addr_out,
  input wire logic [4:0] raster_addr_out
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  logic e_q, wr_q;
  logic [4:0] d_q, ptr_q, vs_lines_q;
  logic [7:0] hs_cnt_q;
  // Shadow of the pointer register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      e_q <= 1'b0;
      wr_q <= 1'b0;
      d_q <= 5'h00;
      ptr_q <= 5'h00;
    end else begin
      e_q <= bus_e;
      wr_q <= !bus_cs_n && !register_select && !bus_read;
      d_q <= bus_data_in[4:0];
      if (e_q && !bus_e && wr_q) begin
        ptr_q <= d_q;
      end
    end
  end
  // Sync pulse width counters
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hs_cnt_q <= 8'h00;
      vs_lines_q <= 5'h00;
    end else begin
      hs_cnt_q <= hsync_out ? hs_cnt_q + {7'h00, hs_cnt_q != 8'hff} : 8'h00;
      vs_lines_q <= !vsync_out ? 5'h00 :
        vs_lines_q + {4'h0, $rose(hsync_out) && vs_lines_q != 5'h1f};
    end
  end
  sequence pin_reset_s;
    (!reset_low_in && !pen_strobe_in)[*8];
  endsequence
  read_drive_a: assert property (
    bus_data_oe == $past(bus_e && !bus_cs_n && bus_read && register_select, 3))
    else $error("Read drive not three clocks behind strobe");
  write_only_zero_a: assert property (
    bus_data_oe && ptr_q < IDX_REFRESH_START_HIGH |-> bus_data_out == 8'h00)
    else $error("Write-only register read non-zero");
  high_bits_zero_a: assert property (
    bus_data_oe && (ptr_q == IDX_REFRESH_START_HIGH || ptr_q == IDX_CURSOR_LOCATION_HIGH
    || ptr_q == IDX_PEN_CAPTURE_HIGH) |-> bus_data_out[7:6] == 2'b00)
    else $error("High byte top bits not zero");
  pin_reset_sync_a: assert property (pin_reset_s |-> !hsync_out && !vsync_out)
    else $error("Sync active during pin reset");
  pin_reset_video_a: assert property (
    pin_reset_s |-> !display_enable_out && !cursor_video_out)
    else $error("Video active during pin reset");
  pin_reset_addr_a: assert property (
    pin_reset_s |-> refresh_addr_out == 14'h0000 && raster_addr_out == 5'h00)
    else $error("Addresses not cleared during pin reset");
  hsync_width_a: assert property (hs_cnt_q <= 15 * CHAR_DIV)
    else $error("Horizontal sync longer than fifteen characters");
  vsync_lines_a: assert property (vs_lines_q <= 5'd16)
    else $error("Vertical sync longer than sixteen lines");
  cover property (pin_reset_s);
  cover property ($rose(bus_data_oe));
  cover property ($rose(cursor_video_out));
  cover property ($rose(vsync_out));
endmodule

bind crtvt_core crtvt_core_properties #(.CHAR_DIV(CHAR_DIV)) u_props (
  .core_clk(core_clk), .rst_n(rst_n), .reset_low_in(reset_low_in),
  .pen_strobe_in(pen_strobe_in), .bus_e(bus_e), .bus_cs_n(bus_cs_n),
  .register_select(register_select), .bus_read(bus_read), .bus_data_in(bus_data_in),
  .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe), .hsync_out(hsync_out),
  .vsync_out(vsync_out), .display_enable_out(display_enable_out),
  .cursor_video_out(cursor_video_out), .refresh_addr_out(refresh_addr_out),
  .raster_addr_out(raster_addr_out)
);

// >>> testbench/crtvt_host_model.sv
// Host processor model on the indirect register bus.
// Assumes the caller waits out reset before the first put or get.
`timescale 1ns/1ps
module crtvt_host_model (
  input wire logic core_clk,
  input wire logic [7:0] bus_data_out,
  input wire logic bus_data_oe,
  output logic bus_e,
  output logic bus_cs_n,
  output logic register_select,
  output logic bus_read,
  output logic [7:0] bus_data_in,
  output logic rd_done,
  output logic [7:0] rd_value
);
  initial begin
    bus_e = 1'b0;
    bus_cs_n = 1'b1;
    register_select = 1'b0;
    bus_read = 1'b1;
    bus_data_in = 8'h00;
    rd_done = 1'b0;
    rd_value = 8'h00;
  end
  // Strobe high four to six clocks; select and data held one clock past its fall
  task automatic phase(input logic sel, input logic rd, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    bus_cs_n = 1'b0;
    register_select = sel;
    bus_read = rd;
    bus_data_in = d;
    bus_e = 1'b1;
    repeat ($urandom_range(6, 4)) @(posedge core_clk);
    rd_value = bus_data_oe ? bus_data_out : 8'hxx;
    #1;
    rd_done = rd;
    bus_e = 1'b0;
    @(posedge core_clk);
    #1;
    rd_done = 1'b0;
    bus_cs_n = 1'b1;
    bus_data_in = ~d;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic put(input logic [4:0] idx, input logic [7:0] d);
    phase(1'b0, 1'b0, {3'b000, idx});
    phase(1'b1, 1'b0, d);
  endtask
  task automatic get(input logic [4:0] idx);
    phase(1'b0, 1'b0, {3'b000, idx});
    phase(1'b1, 1'b1, 8'h00);
  endtask
endmodule

// >>> testbench/crt_vertical_cursor_timing_regs_tb_top.sv
// Self-checking bench for the raster timing core.
// Assumes the package, host model and bound checker are compiled first.
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
  $display("ERROR %0t got %h exp %h", $time, (a), (e)); end end
module crt_vertical_cursor_timing_regs_tb_top;
  import crtvt_pkg::*;
  logic core_clk, rst_n, reset_low_in, pen_strobe_in;
  logic bus_e, bus_cs_n, register_select, bus_read, bus_data_oe, rd_done;
  logic [7:0] bus_data_in, bus_data_out, rd_value, v;
  logic hsync_out, vsync_out, display_enable_out, cursor_video_out;
  logic [13:0] refresh_addr_out;
  logic [4:0] raster_addr_out;
  logic [15:0] ex;
  logic [15:0] exp_q[$];
  logic [7:0] cfg[12];
  int miscompares = 0;
  int cmp_count = 0;
  int per, vw, hw, dw, cw, df, cf, df0, cf0, tot, lines;
  crtvt_core #(.CHAR_DIV(1)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .reset_low_in(reset_low_in),
    .pen_strobe_in(pen_strobe_in), .bus_e(bus_e), .bus_cs_n(bus_cs_n),
    .register_select(register_select), .bus_read(bus_read), .bus_data_in(bus_data_in),
    .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe), .hsync_out(hsync_out),
    .vsync_out(vsync_out), .display_enable_out(display_enable_out),
    .cursor_video_out(cursor_video_out), .refresh_addr_out(refresh_addr_out),
    .raster_addr_out(raster_addr_out));
  crtvt_host_model host (
    .core_clk(core_clk), .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe),
    .bus_e(bus_e), .bus_cs_n(bus_cs_n), .register_select(register_select),
    .bus_read(bus_read), .bus_data_in(bus_data_in), .rd_done(rd_done), .rd_value(rd_value));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #1_600_000;
    miscompares++;
    tally_and_finish();
  end
  // Read results checked against the oldest expectation
  always @(posedge core_clk) begin
    if (rd_done === 1'b1) begin
      ex = exp_q.pop_front();
      `CHK(rd_value & ex[15:8], ex[7:0])
    end
  end
  task automatic rd(input logic [4:0] idx, input logic [7:0] m, input logic [7:0] e);
    exp_q.push_back({m, e});
    host.get(idx);
  endtask
  task automatic cfgw(input int i, input logic [7:0] d);
    cfg[i] = d;
    host.put(i[4:0], d);
  endtask
  // Counts one frame from a vsync rise to the next
  task automatic frame();
    logic p;
    per = 0; vw = 0; hw = 0; dw = 0; cw = 0; df = -1; cf = -1;
    do begin
      if (display_enable_out && df < 0) df = per;
      if (cursor_video_out && cf < 0) cf = per;
      per++; vw += vsync_out; hw += hsync_out; dw += display_enable_out;
      cw += cursor_video_out;
      p = vsync_out;
      @(posedge core_clk);
      #1;
    end while (!(vsync_out && !p));
  endtask
  task automatic measure(input int n);
    logic p;
    do begin
      p = vsync_out;
      @(posedge core_clk);
      #1;
    end while (!(vsync_out && !p));
    frame();
    tot = 0;
    repeat (n) begin
      frame();
      tot += cw;
    end
  endtask
  initial begin
    void'($urandom(32'hb51c_3877));
    rst_n = 1'b0;
    reset_low_in = 1'b1;
    pen_strobe_in = 1'b0;
    repeat (12) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    for (int i = 12; i < 16; i++) begin
      v = $urandom;
      host.put(i[4:0], v);
      rd(i[4:0], 8'hff, i[0] ? v : v & 8'h3f);
    end
    host.put(IDX_PEN_CAPTURE_HIGH, 8'hff);
    rd(IDX_PEN_CAPTURE_HIGH, 8'hff, 8'h00);
    rd(5'h13, 8'hff, 8'h00);
    // 8 chars a line, 5 rows of 4 lines, 2 rows shown, cursor rasters 1 to 2
    cfg = '{8'h07, 8'h03, 8'h05, 8'h02, 8'h04, 8'h00, 8'h02, 8'h01, 8'h00, 8'h03, 8'h01, 8'h02};
    for (int i = 0; i < 12; i++) cfgw(i, cfg[i]);
    rd(IDX_VERTICAL_TOTAL, 8'hff, 8'h00);
    host.put(IDX_CURSOR_LOCATION_HIGH, 8'h00);
    host.put(IDX_CURSOR_LOCATION_LOW, 8'h01);
    host.put(IDX_REFRESH_START_HIGH, 8'h00);
    host.put(IDX_REFRESH_START_LOW, 8'h00);
    for (int k = 0; k < 8; k++) begin
      cfgw(5, 8'(3 * k[0]));
      cfgw(3, {k[1] ? 4'h5 : 4'h0, 4'h2});
      cfgw(8, {6'h00, k[2], 1'b0});
      measure(1);
      lines = (cfg[4] + 1) * (cfg[9] + 1) + cfg[5];
      `CHK(per, lines * 8)
      `CHK(vw, (k[1] ? 5 : 16) * 8)
      `CHK(hw, lines * 2)
    end
    // Interlaced modes: two fields sum to the full raster count, vsync offset differs
    for (int m = 1; m < 4; m += 2) begin
      cfgw(8, 8'(m));
      measure(1);
      tot = per;
      frame();
      df0 = (cfg[4] + 1) * (m == 1 ? 2 * cfg[9] + 2 : cfg[9] + 2) + 2 * cfg[5];
      `CHK(tot + per, df0 * 8)
      `CHK(tot != per, 1'b1)
    end
    for (int d = 0; d < 4; d++) begin
      cfgw(8, {d[1:0], d[1:0], 4'h0});
      measure(1);
      if (d == 0) begin
        df0 = df;
        cf0 = cf;
      end
      `CHK(dw, d == 3 ? 0 : 24)
      `CHK(cw, d == 3 ? 0 : 2)
      if (d < 3) begin
        `CHK(df - df0, d)
        `CHK(cf - cf0, d)
      end
    end
    cfgw(8, 8'h00);
    for (int m = 0; m < 4; m++) begin
      cfgw(10, {1'b0, m[1:0], 5'h01});
      measure(m == 3 ? 64 : 32);
      `CHK(tot, m == 1 ? 0 : (m == 2 ? 32 : 64))
    end
    cfgw(10, 8'h01);
    host.put(IDX_REFRESH_START_HIGH, 8'h01);
    host.put(IDX_REFRESH_START_LOW, 8'h23);
    host.put(IDX_CURSOR_LOCATION_HIGH, 8'h01);
    for (int c = 4; c < 7; c += 2) begin
      host.put(IDX_CURSOR_LOCATION_LOW, 8'(8'h23 + c));
      measure(2);
      `CHK(tot, c == 4 ? 4 : 0)
    end
    pen_strobe_in = 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    pen_strobe_in = 1'b0;
    rd(IDX_PEN_CAPTURE_HIGH, 8'hff, 8'h01);
    reset_low_in = 1'b0;
    repeat (20) @(posedge core_clk);
    #1;
    `CHK({vsync_out, hsync_out, display_enable_out, refresh_addr_out}, 17'h0_0000)
    reset_low_in = 1'b1;
    measure(1);
    `CHK(per, lines * 8)
    rd(IDX_CURSOR_LOCATION_LOW, 8'hff, 8'h29);
    tally_and_finish();
  end
endmodule
